// File: common/pid_pkg.sv
package pid_pkg;

   // ----------------------------------------
   // Clock and control update timing
   // ----------------------------------------
   localparam int unsigned CLK_MHZ = 125;           // System clock rate in MHz
   localparam int unsigned TICK_US_DEFAULT = 1000;  // Control update period in us

   // ----------------------------------------
   // Function select codes
   // ----------------------------------------
   localparam logic [2:0] FSEL_OFF = 3'h0;          // Regulation disabled
   localparam logic [2:0] FSEL_D_FB = 3'h1;         // Derivative on feedback
   localparam logic [2:0] FSEL_D_FF = 3'h2;         // Derivative as feed-forward
   localparam logic [2:0] FSEL_ADD_D_FB = 3'h3;     // Added to reference, D on feedback
   localparam logic [2:0] FSEL_ADD_D_FF = 3'h4;     // Added to reference, D feed-forward

   // ----------------------------------------
   // Setting values taken at reset
   // ----------------------------------------
   localparam logic [2:0] FSEL_RESET = 3'h0;
   localparam logic [11:0] KP_RESET = 12'h064;      // 1.00 in 0.01 steps
   localparam logic [11:0] TI_RESET = 12'h00a;      // 1.0 s in 0.1 s steps
   localparam logic [9:0] ICLAMP_RESET = 10'h3e8;   // 100.0 % in 0.1 % steps
   localparam logic [9:0] TD_RESET = 10'h000;       // 0.00 s
   localparam logic [9:0] OCLAMP_RESET = 10'h3e8;   // 100.0 %
   localparam logic [10:0] OFFSET_RESET = 11'h000;  // 0.0 %
   localparam logic [9:0] LAG_RESET = 10'h000;      // 0.00 s

   // ----------------------------------------
   // Scaling of settings and values
   // ----------------------------------------
   localparam int unsigned TI_UNIT_US = 100000;     // Integral time step, 0.1 s
   localparam int unsigned TD_UNIT_US = 10000;      // Derivative time step, 0.01 s
   localparam int unsigned LAG_UNIT_US = 10000;     // Lag time step, 0.01 s
   localparam int unsigned PCT_TENTH = 10;          // 0.1 % step in 0.01 % value units
   localparam int unsigned FULL_SCALE = 10000;      // 100.00 % of maximum frequency
   localparam int unsigned FRAC = 16;               // Fraction bits of accumulators
   localparam int unsigned GAIN_RECIP = 5243;       // Multiply then shift: divide by 100
   localparam int unsigned GAIN_SHIFT = 19;
   localparam int unsigned DIV_DW = 56;             // Divider dividend width
   localparam int unsigned DIV_VW = 32;             // Divider divisor width

   // ----------------------------------------
   // Sequencer states
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_INT,
      ST_DER,
      ST_SUM,
      ST_LAG,
      ST_OUT
   } pid_state_t;

endpackage

// File: logic/pid_div.sv
`timescale 1ns/1ps
module pid_div
   import pid_pkg::*;
#(
   parameter int DW = 56,
   parameter int VW = 32
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Request
   input wire logic i_start,
   input wire logic [DW-1:0] i_dividend,
   input wire logic [VW-1:0] i_divisor,
   // Result
   output logic o_done,
   output logic [DW-1:0] o_quot
);

   localparam int CW = $clog2(DW + 1);

   typedef struct packed {
      logic busy;
      logic done;
      logic [CW-1:0] cnt;
      logic [VW:0] rem;
      logic [DW-1:0] quot;
      logic [VW-1:0] dvs;
   } pid_div_t;

   pid_div_t r;
   pid_div_t next_r;

   // Restoring division, one quotient bit per clock
   always_comb begin
      logic [VW:0] trial;
      trial = '0;
      next_r = r;
      next_r.done = 1'b0;
      if (i_start && !r.busy) begin
         next_r.busy = 1'b1;
         next_r.cnt = CW'(DW);
         next_r.rem = '0;
         next_r.quot = i_dividend;
         next_r.dvs = i_divisor;
      end else if (r.busy) begin
         trial = {r.rem[VW-1:0], r.quot[DW-1]};
         if (trial >= {1'b0, r.dvs}) begin
            next_r.rem = trial - {1'b0, r.dvs};
            next_r.quot = {r.quot[DW-2:0], 1'b1};
         end else begin
            next_r.rem = trial;
            next_r.quot = {r.quot[DW-2:0], 1'b0};
         end
         next_r.cnt = r.cnt - CW'(1);
         if (r.cnt == CW'(1)) begin
            next_r.busy = 1'b0;
            next_r.done = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign o_done = r.done;
   assign o_quot = r.quot;

endmodule

// File: logic/pid_regulator.sv
`timescale 1ns/1ps
// How it works
// - Regulate only when function select is 1-4
// - Select decodes disable, D placement, reference adding
// - Proportional gain multiplies setpoint minus feedback error
// - Feedback comes from the second analog input
// - Integrator accumulates error every control update
// - Integral step inversely proportional to integral time
// - Integral time zero disables the integral term
// - Integrator clamped to percentage of maximum frequency
// - Derivative time zero removes the derivative term
// - Total output clamped to percentage of maximum
// - Signed percentage offset added to the output
// - Output passes through a programmable low-pass filter
module pid_regulator
   import pid_pkg::*;
#(
   parameter int unsigned TICK_US = TICK_US_DEFAULT
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Settings
   input wire logic [2:0] i_regulator_function_select,
   input wire logic [11:0] i_proportional_gain,
   input wire logic [11:0] i_integral_time,
   input wire logic [9:0] i_integral_clamp,
   input wire logic [9:0] i_derivative_time,
   input wire logic [9:0] i_regulator_output_clamp,
   input wire logic signed [10:0] i_regulator_output_offset,
   input wire logic [9:0] i_output_lag_time_constant,
   // Process values, 0.01 % of maximum output frequency
   input wire logic signed [15:0] i_setpoint,
   input wire logic signed [15:0] i_second_analog_input,
   input wire logic signed [15:0] i_frequency_reference,
   // Results
   output logic o_regulator_active,
   output logic o_update,
   output logic signed [15:0] o_regulator_output,
   output logic signed [15:0] o_frequency_command
);

   // ----------------------------------------
   // Constants and state
   // ----------------------------------------
   localparam int unsigned TICK_CYC = TICK_US * CLK_MHZ;
   localparam logic signed [47:0] FS48 = 48'(FULL_SCALE);
   // Derivative bound, far above any output, keeps the shifted term in range
   localparam logic signed [47:0] D_MAX = 48'sh100000;

   typedef struct packed {
      pid_state_t state;
      logic [31:0] tick_cnt;
      logic [2:0] fsel;
      logic [11:0] kp;
      logic [11:0] ti;
      logic [9:0] iclamp;
      logic [9:0] td;
      logic [9:0] oclamp;
      logic signed [10:0] offset;
      logic [9:0] lag;
      logic first;
      logic signed [47:0] p_term;
      logic signed [47:0] pd;
      logic signed [47:0] integ;
      logic signed [47:0] d_term;
      logic signed [47:0] lag_in;
      logic signed [47:0] filt;
      logic signed [15:0] prev_fb;
      logic signed [15:0] prev_err;
      logic neg;
      logic div_start;
      logic div_wait;
      logic [DIV_DW-1:0] div_dividend;
      logic [DIV_VW-1:0] div_divisor;
      logic active;
      logic update;
      logic signed [15:0] reg_out;
      logic signed [15:0] freq_cmd;
   } pid_reg_t;

   pid_reg_t r;
   pid_reg_t next_r;
   logic div_done;
   logic [DIV_DW-1:0] div_quot;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Symmetric clamp to plus or minus a limit
   function automatic logic signed [47:0] sat(input logic signed [47:0] x, input logic signed [47:0] lim);
      logic signed [47:0] y;
      y = x;
      if (x > lim) begin
         y = lim;
      end else if (x < -lim) begin
         y = -lim;
      end
      return y;
   endfunction

   // Magnitude for the unsigned divider
   function automatic logic [47:0] mag(input logic signed [47:0] x);
      return (x < 0) ? 48'(-x) : 48'(x);
   endfunction

   // Gain in 0.01 steps times a value, scaled back by 100
   function automatic logic signed [47:0] gain(input logic [11:0] kp, input logic signed [47:0] v);
      logic signed [47:0] m;
      m = $signed({36'h0, kp}) * v;
      return (m * $signed(48'(GAIN_RECIP))) >>> GAIN_SHIFT;
   endfunction

   // ----------------------------------------
   // Shared sequential divider
   // ----------------------------------------
   pid_div #(
      .DW(DIV_DW),
      .VW(DIV_VW)
   ) u_div (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_start(r.div_start),
      .i_dividend(r.div_dividend),
      .i_divisor(r.div_divisor),
      .o_done(div_done),
      .o_quot(div_quot)
   );

   // ----------------------------------------
   // Update sequencer
   // ----------------------------------------
   always_comb begin
      logic signed [47:0] err;
      logic signed [47:0] delta;
      logic signed [47:0] q;
      logic signed [47:0] dq;
      logic signed [47:0] sum;
      logic signed [47:0] outv;
      logic tick;
      logic run;
      err = '0;
      delta = '0;
      sum = '0;
      outv = '0;
      dq = '0;
      q = $signed(div_quot[47:0]);
      next_r = r;
      next_r.div_start = 1'b0;
      next_r.update = 1'b0;
      // Free-running update tick, one per control period
      tick = (r.tick_cnt == TICK_CYC - 1);
      next_r.tick_cnt = tick ? 32'h0 : r.tick_cnt + 32'h1;
      // Select 1-4 enables the loop; checked live while idle
      run = (i_regulator_function_select >= FSEL_D_FB) &&
            (i_regulator_function_select <= FSEL_ADD_D_FF);
      case (r.state)
         // Wait for a tick, then snapshot settings and form P
         ST_IDLE: begin
            if (!run) begin
               // Regulation idle: clear history, pass the reference through
               next_r.active = 1'b0;
               next_r.first = 1'b1;
               next_r.integ = '0;
               next_r.filt = '0;
               next_r.reg_out = '0;
               next_r.freq_cmd = i_frequency_reference;
            end else if (tick) begin
               next_r.fsel = i_regulator_function_select;
               next_r.kp = i_proportional_gain;
               next_r.ti = i_integral_time;
               next_r.iclamp = i_integral_clamp;
               next_r.td = i_derivative_time;
               next_r.oclamp = i_regulator_output_clamp;
               next_r.offset = i_regulator_output_offset;
               next_r.lag = i_output_lag_time_constant;
               err = 48'(i_setpoint) - 48'(i_second_analog_input);
               next_r.p_term = gain(i_proportional_gain, err);
               if (i_regulator_function_select == FSEL_D_FB ||
                   i_regulator_function_select == FSEL_ADD_D_FB) begin
                  delta = 48'(r.prev_fb) - 48'(i_second_analog_input);
               end else begin
                  delta = err - 48'(r.prev_err);
               end
               next_r.pd = gain(i_proportional_gain, delta);
               next_r.prev_fb = i_second_analog_input;
               next_r.prev_err = err[15:0];
               if (i_integral_time != 12'h0) begin
                  // Step = P * Ts / Ti, kept with fraction bits
                  next_r.neg = next_r.p_term < 0;
                  next_r.div_dividend = (DIV_DW'(mag(next_r.p_term)) * DIV_DW'(TICK_US)) << FRAC;
                  next_r.div_divisor = DIV_VW'(i_integral_time) * DIV_VW'(TI_UNIT_US);
                  next_r.div_start = 1'b1;
                  next_r.state = ST_INT;
               end else begin
                  next_r.integ = '0;
                  next_r.state = ST_DER;
               end
            end
         end
         // Integrate the step and clamp the integrator
         ST_INT: begin
            if (div_done) begin
               sum = r.neg ? r.integ - q : r.integ + q;
               next_r.integ = sat(sum, (48'(r.iclamp) * 48'(PCT_TENTH)) <<< FRAC);
               next_r.state = ST_DER;
            end
         end
         // Derivative term: one division per update, a flag waits for it
         ST_DER: begin
            if (r.td == 10'h0 || r.first) begin
               next_r.d_term = '0;
               next_r.state = ST_SUM;
            end else if (!r.div_wait) begin
               // D = Kp * Td * change / Ts
               next_r.neg = r.pd < 0;
               next_r.div_dividend = DIV_DW'(mag(r.pd)) * DIV_DW'(r.td) * DIV_DW'(TD_UNIT_US);
               next_r.div_divisor = DIV_VW'(TICK_US);
               next_r.div_start = 1'b1;
               next_r.div_wait = 1'b1;
            end else if (div_done) begin
               // Bound the quotient so the shift below cannot wrap
               dq = (q > D_MAX) ? D_MAX : q;
               next_r.d_term = r.neg ? -(dq <<< FRAC) : (dq <<< FRAC);
               next_r.div_wait = 1'b0;
               next_r.state = ST_SUM;
            end
         end
         // Output chain, then start the lag step if needed
         ST_SUM: begin
            // Sum, limit, then offset
            sum = (r.p_term <<< FRAC) + r.integ + r.d_term;
            sum = sat(sum, (48'(r.oclamp) * 48'(PCT_TENTH)) <<< FRAC);
            sum = sum + ((48'(r.offset) * 48'(PCT_TENTH)) <<< FRAC);
            next_r.lag_in = sum;
            if (r.lag == 10'h0 || r.first) begin
               next_r.filt = sum;
               next_r.state = ST_OUT;
            end else begin
               // Lag step = (x - y) * Ts / (Tf + Ts)
               next_r.neg = (sum - r.filt) < 0;
               next_r.div_dividend = DIV_DW'(mag(sum - r.filt)) * DIV_DW'(TICK_US);
               next_r.div_divisor = DIV_VW'(r.lag) * DIV_VW'(LAG_UNIT_US) + DIV_VW'(TICK_US);
               next_r.div_start = 1'b1;
               next_r.state = ST_LAG;
            end
         end
         // Move the filter state by the lag step
         ST_LAG: begin
            if (div_done) begin
               next_r.filt = r.neg ? r.filt - q : r.filt + q;
               next_r.state = ST_OUT;
            end
         end
         // Publish output and command, pulse the update flag
         ST_OUT: begin
            outv = sat(r.filt >>> FRAC, FS48 + FS48);
            next_r.reg_out = outv[15:0];
            if (r.fsel >= FSEL_ADD_D_FB) begin
               outv = sat(outv + 48'(i_frequency_reference), FS48);
            end else begin
               outv = sat(outv, FS48);
            end
            next_r.freq_cmd = outv[15:0];
            next_r.active = 1'b1;
            next_r.update = 1'b1;
            next_r.first = 1'b0;
            next_r.state = ST_IDLE;
         end
         default: begin
            next_r.state = ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         r <= '0;
         r.state <= ST_IDLE;
         r.fsel <= FSEL_RESET;
         r.kp <= KP_RESET;
         r.ti <= TI_RESET;
         r.iclamp <= ICLAMP_RESET;
         r.td <= TD_RESET;
         r.oclamp <= OCLAMP_RESET;
         r.offset <= OFFSET_RESET;
         r.lag <= LAG_RESET;
         r.first <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // Outputs straight from the state register
   assign o_regulator_active = r.active;
   assign o_update = r.update;
   assign o_regulator_output = r.reg_out;
   assign o_frequency_command = r.freq_cmd;

endmodule

// File: tb/pid_sensor.sv
`timescale 1ns/1ps
module pid_sensor (
   // Clock
   input wire logic i_clk,
   // Levels asked for by the bench
   input wire logic signed [15:0] i_fb_level,
   input wire logic signed [15:0] i_ref_level,
   // Toward the regulator
   output logic signed [15:0] o_feedback,
   output logic signed [15:0] o_reference
);
   // ----------------------------------------
   // Transducer and reference path
   // ----------------------------------------
   // Settled values from time zero
   initial begin
      o_feedback = 16'sh0000;
      o_reference = 16'sh0000;
   end
   // New readings land off the sampling edge
   always @(negedge i_clk) begin
      o_feedback <= i_fb_level;
      o_reference <= i_ref_level;
   end
endmodule

// File: tb/pid_regulator_sva.sv
`timescale 1ns/1ps
module pid_regulator_sva
   import pid_pkg::*;
#(
   parameter int unsigned TICK_US = TICK_US_DEFAULT
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Settings and reference
   input wire logic [2:0] i_regulator_function_select,
   input wire logic [9:0] i_regulator_output_clamp,
   input wire logic signed [10:0] i_regulator_output_offset,
   input wire logic [9:0] i_output_lag_time_constant,
   input wire logic signed [15:0] i_frequency_reference,
   // Results
   input wire logic o_regulator_active,
   input wire logic o_update,
   input wire logic signed [15:0] o_regulator_output,
   input wire logic signed [15:0] o_frequency_command
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   logic on;
   logic [2:0] sel;
   assign sel = i_regulator_function_select;
   assign on = (sel != 3'h0) && (sel < 3'h5);
   // Saturate to full scale
   function automatic logic signed [15:0] sat(input logic signed [17:0] v);
      return (v > 18'sh02710) ? 16'sh2710 : ((v < -18'sh02710) ? -16'sh2710 : v[15:0]);
   endfunction
   default clocking dc @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   idle_zero_a: assert property ((!on) [*2] |-> !o_regulator_active && o_regulator_output == 16'sh0000)
      else $error("output not cleared while off");
   idle_cmd_a: assert property ((!on) [*2] |-> o_frequency_command == $past(i_frequency_reference))
      else $error("command does not follow reference while off");
   pulse_gap_a: assert property (o_update |=> (!o_update) [*8])
      else $error("update pulse too long or too close");
   update_on_a: assert property (o_update |-> o_regulator_active && on)
      else $error("update without valid select");
   add_ref_a: assert property (o_update && (sel == 3'h3 || sel == 3'h4) && $stable(i_frequency_reference)
      |-> o_frequency_command == sat(18'(i_frequency_reference) + 18'(o_regulator_output)))
      else $error("command is not reference plus output");
   direct_cmd_a: assert property (o_update && (sel == 3'h1 || sel == 3'h2)
      |-> o_frequency_command == sat(18'(o_regulator_output)))
      else $error("command is not regulator output");
   hold_out_a: assert property (o_regulator_active && !o_update |-> $stable(o_regulator_output))
      else $error("output moved between updates");
   zero_clamp_a: assert property (o_update && i_regulator_output_clamp == 10'h000
      && i_regulator_output_offset == 11'sh000 && i_output_lag_time_constant == 10'h000
      |-> o_regulator_output == 16'sh0000)
      else $error("zero clamp not applied");
endmodule

bind pid_regulator pid_regulator_sva #(.TICK_US(TICK_US)) sva (
   .i_clk(i_clk), .i_rst(i_rst), .i_regulator_function_select(i_regulator_function_select),
   .i_regulator_output_clamp(i_regulator_output_clamp), .i_regulator_output_offset(i_regulator_output_offset),
   .i_output_lag_time_constant(i_output_lag_time_constant), .i_frequency_reference(i_frequency_reference),
   .o_regulator_active(o_regulator_active), .o_update(o_update),
   .o_regulator_output(o_regulator_output), .o_frequency_command(o_frequency_command)
);

// File: tb/pid_regulator_test.sv
`timescale 1ns/1ps
module pid_regulator_test;
   import pid_pkg::*;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [2:0] sel = 3'h0;
   logic [11:0] kp = 12'h064;
   logic [11:0] ti = 12'h000;
   logic [9:0] ic = 10'h3e8;
   logic [9:0] td = 10'h000;
   logic [9:0] oc = 10'h3e8;
   logic signed [10:0] ofs = 11'sh000;
   logic [9:0] lg = 10'h000;
   logic signed [15:0] sp = 16'sh0000;
   logic signed [15:0] fbl = 16'sh0000;
   logic signed [15:0] rfl = 16'sh0000;
   logic signed [15:0] fb, rf, out, cmd;
   logic act, upd;
   int err_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int s, k, p, f, r, c, o, e;
   always #4 i_clk = ~i_clk;
   pid_sensor sensor (.i_clk(i_clk), .i_fb_level(fbl), .i_ref_level(rfl), .o_feedback(fb), .o_reference(rf));
   pid_regulator #(.TICK_US(2)) uut (
      .i_clk(i_clk), .i_rst(i_rst), .i_regulator_function_select(sel), .i_proportional_gain(kp),
      .i_integral_time(ti), .i_integral_clamp(ic), .i_derivative_time(td), .i_regulator_output_clamp(oc),
      .i_regulator_output_offset(ofs), .i_output_lag_time_constant(lg), .i_setpoint(sp),
      .i_second_analog_input(fb), .i_frequency_reference(rf), .o_regulator_active(act),
      .o_update(upd), .o_regulator_output(out), .o_frequency_command(cmd)
   );
   // ----------------------------------------
   // Model, checks and drivers
   // ----------------------------------------
   // Limit, then offset, without lag
   function automatic int exp_out(int gain, int err, int lim, int off);
      longint v;
      v = (longint'(gain) * err * 5243) >>> 19;
      v = (v > lim * 10) ? lim * 10 : ((v < -lim * 10) ? -lim * 10 : v);
      return int'(v) + off * 10;
   endfunction
   // Command as seen by the speed path
   function automatic int exp_cmd(int fs, int ref_v, int y);
      int v;
      v = (fs >= 3) ? ref_v + y : y;
      return (v > 10000) ? 10000 : ((v < -10000) ? -10000 : v);
   endfunction
   task automatic check16(input string what, input int exp, input logic signed [15:0] got);
      n_checks++;
      if (got !== 16'(exp)) begin
         err_count++;
         $display("wrong value %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   task automatic check1(input string what, input logic exp, input logic got);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic check_all(input int fs, input int y, input int ref_v);
      check16("output", y, out);
      check16("command", exp_cmd(fs, ref_v, y), cmd);
      check1("active", 1'b1, act);
   endtask
   // Levels first, settings one cycle later
   task automatic setup(input int fs, gain, t_i, icl, t_d, ocl, off, lag, sp_v, fb_v, ref_v);
      fbl = 16'(fb_v);
      rfl = 16'(ref_v);
      sp = 16'(sp_v);
      @(negedge i_clk);
      sel = 3'(fs);
      kp = 12'(gain);
      ti = 12'(t_i);
      ic = 10'(icl);
      td = 10'(t_d);
      oc = 10'(ocl);
      ofs = 11'(off);
      lg = 10'(lag);
   endtask
   // Next update pulse, bounded
   task automatic wait_update;
      int n;
      n = 0;
      do begin
         @(negedge i_clk);
         n++;
      end while (upd !== 1'b1 && n < 600);
      if (n >= 600) begin
         err_count++;
         $display("wrong value update expected 1 seen none");
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Hang guard
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 80000) begin
         err_count++;
         $display("wrong value cycles expected below 80000 seen 80000");
         test_done();
      end
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      void'($urandom(55));
      repeat (6) @(posedge i_clk);
      @(negedge i_clk);
      i_rst = 1'b0;
      // Every select code
      for (int fs = 0; fs < 8; fs++) begin
         setup(fs, 100, 0, 1000, 0, 1000, 5, 0, 3000, 1000, 2000);
         if (fs >= 1 && fs <= 4) begin
            wait_update();
            check_all(fs, exp_out(100, 2000, 1000, 5), 2000);
         end else begin
            repeat (3) @(negedge i_clk);
            check1("active", 1'b0, act);
            check16("output", 0, out);
            check16("command", 2000, cmd);
         end
      end
      $display("select table done");
      // Random gain, error, limit and offset
      for (int i = 0; i < 8; i++) begin
         s = int'($urandom_range(4, 1));
         k = int'($urandom_range(2500, 0));
         c = (i == 0) ? 0 : int'($urandom_range(1000, 0));
         o = (i == 0) ? 0 : int'($urandom_range(2000, 0)) - 1000;
         f = int'($urandom_range(10000, 0));
         p = f + int'($urandom_range(10000 - f, 0));
         r = int'($urandom_range(20000, 0)) - 10000;
         setup(s, k, 0, 1000, 0, c, o, 0, p, f, r);
         wait_update();
         check_all(s, exp_out(k, p - f, c, o), r);
      end
      $display("random settings done");
      // Derivative placement and zero time
      for (int j = 0; j < 5; j++) begin
         s = j % 4 + 1;
         setup(0, 100, 0, 1000, 1, 500, 0, 0, 3000, 1000, 0);
         repeat (3) @(negedge i_clk);
         setup(s, 100, 0, 1000, (j < 4) ? 1 : 0, 500, 0, 0, 3000, 1000, 0);
         wait_update();
         setup(s, 100, 0, 1000, (j < 4) ? 1 : 0, 500, 0, 0, 3010, 1010, 0);
         wait_update();
         e = (s % 2 == 1 && j < 4) ? -5000 : exp_out(100, 2000, 500, 0);
         check_all(s, e, 0);
      end
      $display("derivative done");
      // Lag holds a small step, zero time bypasses it
      setup(0, 100, 0, 1000, 0, 1000, 0, 1, 3000, 1000, 0);
      repeat (3) @(negedge i_clk);
      setup(1, 100, 0, 1000, 0, 1000, 0, 1, 3000, 1000, 0);
      wait_update();
      check16("output", 2000, out);
      setup(1, 100, 0, 1000, 0, 1000, 0, 1, 3100, 1000, 0);
      wait_update();
      check16("output", 2000, out);
      setup(1, 100, 0, 1000, 0, 1000, 0, 0, 3100, 1000, 0);
      wait_update();
      check16("output", 2100, out);
      $display("lag done");
      // Integral growth, strength and clamp
      for (int t = 0; t < 3; t++) begin
         setup(0, 900, t, 1, 0, 1000, 0, 0, 2000, 1000, 0);
         repeat (3) @(negedge i_clk);
         setup(1, 900, t, 1, 0, 1000, 0, 0, 2000, 1000, 0);
         repeat (60) wait_update();
         p = exp_out(900, 1000, 1000, 0);
         e = (t == 0) ? 0 : (60 * ((p * 2 * 65536) / (t * 100000))) >>> 16;
         check16("output", p + ((e > 10) ? 10 : e), out);
      end
      $display("integral done");
      test_done();
   end
endmodule
